// *** eil_pkg.sv ***
// package: constants and carrier types for the external interrupt latch
package eil_pkg;
    localparam int EIL_DW = 32;
    localparam int EIL_AW = 8;
    // register byte offsets
    localparam logic [7:0] EIL_OFF_SCR = 8'h00;
    localparam logic [7:0] EIL_OFF_BRK = 8'h04;
    localparam logic [7:0] EIL_OFF_EVT = 8'h08;
    localparam logic [7:0] EIL_OFF_EMSK = 8'h0C;
    // ext_int_status_control field positions
    localparam int EIL_SCR_MODE = 0;
    localparam int EIL_SCR_MASK = 1;
    localparam int EIL_SCR_ACK = 2;
    localparam int EIL_SCR_PEND = 3;
    // break control field position
    localparam int EIL_BRK_BCE = 0;
    // event status bit positions
    localparam int EIL_EVT_EDGE = 0;
    localparam int EIL_EVT_VEC = 1;
    localparam int EIL_EVT_NUM = 2;
    // values after reset
    localparam logic EIL_RST_MODE = 1'b0;
    localparam logic EIL_RST_MASK = 1'b0;
    localparam logic EIL_RST_BCE = 1'b0;
    localparam logic EIL_RST_LATCH = 1'b0;
    localparam logic EIL_RST_PIN = 1'b1;
    localparam logic [EIL_EVT_NUM-1:0] EIL_RST_EVT = 2'h0;

    typedef struct packed {
        logic pend;
        logic ack;
        logic mask;
        logic mode;
    } eil_scr_t;

    typedef struct packed {
        logic pin_low;
        logic fall;
    } eil_pin_t;
endpackage : eil_pkg

// *** eil_pin_sync.sv ***
// pin synchroniser and falling-edge detector
`timescale 1ns/100ps
`default_nettype none
module eil_pin_sync
    import eil_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_n_i,
    output eil_pin_t pin_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic [2:0] fill_q;

    // no edge until both compared samples really came from the pin, so a pin
    // held low through reset does not raise a false edge afterwards
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fill_q <= 3'h0;
        end else begin
            fill_q <= {fill_q[1:0], 1'b1};
        end
    end

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= EIL_RST_PIN;
            sync_q <= EIL_RST_PIN;
            prev_q <= EIL_RST_PIN;
        end else begin
            meta_q <= pin_n_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign pin_o.pin_low = ~sync_q;
    assign pin_o.fall = fill_q[2] & prev_q & ~sync_q;
endmodule : eil_pin_sync
`default_nettype wire

// *** eil_ext_int.sv ***
// external interrupt latch with wishbone registers
//
// Contract
// - pin falling edge sets request latch
// - vector fetch acknowledge clears the latch
// - software ack write of one clears latch
// - any reset clears the latch
// - edge-only after reset, level selectable
// - edge mode: latch holds until clear
// - level mode: needs ack and pin high
// - ack and pin-high any order, low pends
// - reset clears latch and mode bit
// - mask bit blocks requests to cpu
// - forward only unmasked; mask keeps latch
// - pending flag readable regardless of mask
// - ack bit write-only, reads zero
// - reset clears mask bit
// - break blocks sw ack unless enabled
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module eil_ext_int
    import eil_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_pin_n_i,
    input wire logic vec_fetch_i,
    input wire logic break_state_i,
    output logic cpu_req_o,
    output logic irq_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [EIL_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [EIL_DW-1:0] wb_dat_i,
    output logic [EIL_DW-1:0] wb_dat_o,
    output logic wb_ack_o
);
    eil_pin_t pin;
    logic latch_q;
    logic mode_q;
    logic mask_q;
    logic bce_q;
    logic [EIL_EVT_NUM-1:0] evt_q;
    logic [EIL_EVT_NUM-1:0] emsk_q;
    logic ack_q;
    logic [EIL_DW-1:0] rdat_q;
    logic req;
    logic wr_go;
    logic wr_lane0;
    logic sw_ack;
    logic sw_ack_eff;
    logic pending;
    logic [EIL_DW-1:0] rdat_d;
    eil_scr_t scr_rd;

    function automatic logic hit(input logic [EIL_AW-1:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction : hit

    eil_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_n_i(irq_pin_n_i),
        .pin_o(pin)
    );

    // bus handshake: answer one cycle after the request, write lands on the ack edge
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_go = req & wb_we_i & ack_q;
    assign wr_lane0 = wr_go & wb_sel_i[0];
    assign sw_ack = wr_lane0 & hit(wb_adr_i, EIL_OFF_SCR) & wb_dat_i[EIL_SCR_ACK];
    assign sw_ack_eff = sw_ack & (~break_state_i | bce_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end
    assign wb_ack_o = ack_q;

    // request latch: a new edge wins over any clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= EIL_RST_LATCH;
        end else if (pin.fall) begin
            latch_q <= 1'b1;
        end else if (vec_fetch_i | sw_ack_eff) begin
            latch_q <= 1'b0;
        end
    end

    // level mode keeps the request up while the pin stays low
    assign pending = latch_q | (mode_q & pin.pin_low);
    assign cpu_req_o = pending & ~mask_q;

    // control bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q <= EIL_RST_MODE;
            mask_q <= EIL_RST_MASK;
        end else if (wr_lane0 & hit(wb_adr_i, EIL_OFF_SCR)) begin
            mode_q <= wb_dat_i[EIL_SCR_MODE];
            mask_q <= wb_dat_i[EIL_SCR_MASK];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bce_q <= EIL_RST_BCE;
        end else if (wr_lane0 & hit(wb_adr_i, EIL_OFF_BRK)) begin
            bce_q <= wb_dat_i[EIL_BRK_BCE];
        end
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_q <= EIL_RST_EVT;
        end else begin
            evt_q <= (evt_q & ~((wr_lane0 & hit(wb_adr_i, EIL_OFF_EVT)) ? wb_dat_i[EIL_EVT_NUM-1:0]
                                                                         : EIL_RST_EVT))
                     | {vec_fetch_i, pin.fall};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            emsk_q <= EIL_RST_EVT;
        end else if (wr_lane0 & hit(wb_adr_i, EIL_OFF_EMSK)) begin
            emsk_q <= wb_dat_i[EIL_EVT_NUM-1:0];
        end
    end

    assign irq_o = |(evt_q & emsk_q);

    // read mux; ack field always reads zero
    always_comb begin
        scr_rd.pend = pending;
        scr_rd.ack = 1'b0;
        scr_rd.mask = mask_q;
        scr_rd.mode = mode_q;
        rdat_d = '0;
        unique case (1'b1)
            hit(wb_adr_i, EIL_OFF_SCR): rdat_d[3:0] = scr_rd;
            hit(wb_adr_i, EIL_OFF_BRK): rdat_d[EIL_BRK_BCE] = bce_q;
            hit(wb_adr_i, EIL_OFF_EVT): rdat_d[EIL_EVT_NUM-1:0] = evt_q;
            hit(wb_adr_i, EIL_OFF_EMSK): rdat_d[EIL_EVT_NUM-1:0] = emsk_q;
            default: rdat_d = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= '0;
        end else if (req & ~ack_q & ~wb_we_i) begin
            rdat_q <= rdat_d;
        end
    end
    assign wb_dat_o = rdat_q;

    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence pin_fall_s;
        pin.fall;
    endsequence

    sequence scr_read_s;
        req & ~wb_we_i & ~ack_q & hit(wb_adr_i, EIL_OFF_SCR);
    endsequence

    sequence scr_ack_s;
        ack_q & ~wb_we_i;
    endsequence

    sequence level_clear_s;
        ~latch_q & ~pin.pin_low;
    endsequence

    edge_sets_latch_a: assert property (pin_fall_s |=> latch_q)
        else $error("falling edge did not set the latch");

    vec_clears_a: assert property (vec_fetch_i & ~pin.fall |=> ~latch_q)
        else $error("vector fetch did not clear the latch");

    sw_ack_clears_a: assert property (sw_ack & ~pin.fall & (~break_state_i | bce_q) |=> ~latch_q)
        else $error("software ack did not clear the latch");

    reset_state_a: assert property ($fell(rst_i) |-> ~latch_q & ~mode_q & ~mask_q & ~cpu_req_o)
        else $error("state not cleared by reset");

    edge_hold_a: assert property (latch_q & ~vec_fetch_i & ~sw_ack_eff |=> latch_q)
        else $error("latch dropped without a clear");

    level_pend_a: assert property (mode_q & pin.pin_low |-> pending)
        else $error("level request not pending while pin low");

    level_order_a: assert property (mode_q & latch_q & pin.pin_low & vec_fetch_i & ~pin.fall ##1
                                    mode_q & ~pin.pin_low & ~pin.fall |-> level_clear_s)
        else $error("level request stuck after ack then pin high");

    mask_block_a: assert property (mask_q |-> ~cpu_req_o && (~latch_q || pending))
        else $error("masked request reached the cpu");

    unmasked_fwd_a: assert property (pending & ~mask_q |-> cpu_req_o)
        else $error("unmasked request not forwarded");

    mask_keeps_a: assert property (latch_q & mask_q & ~vec_fetch_i & ~sw_ack_eff |=> latch_q)
        else $error("mask cleared the latch");

    pend_read_a: assert property (scr_read_s ##1 scr_ack_s |->
                                  wb_dat_o[EIL_SCR_PEND] == $past(pending))
        else $error("pending flag read wrong");

    ack_reads_zero_a: assert property (scr_read_s ##1 scr_ack_s |-> ~wb_dat_o[EIL_SCR_ACK])
        else $error("ack bit read as one");

    break_guard_a: assert property (sw_ack & break_state_i & ~bce_q & latch_q & ~vec_fetch_i
                                    |=> latch_q)
        else $error("ack during break cleared the latch");

    edge_shape_a: assert property (pin_fall_s |-> pin.pin_low & ~$past(pin.pin_low))
        else $error("edge flagged without high then low");

    bus_answer_a: assert property (req & ~ack_q |=> wb_ack_o ##1 ~wb_ack_o)
        else $error("bus answer timing wrong");

    irq_level_a: assert property (|(evt_q & emsk_q) |-> irq_o)
        else $error("interrupt output low with unmasked event");

    // bus side: one ack per request, reads come from the addressed register
    sequence rd_at_s(logic [7:0] off);
        req & ~wb_we_i & ~ack_q & hit(wb_adr_i, off);
    endsequence

    sequence wr_at_s(logic [7:0] off);
        wr_lane0 & hit(wb_adr_i, off);
    endsequence

    sequence unmapped_rd_s;
        req & ~wb_we_i & ~ack_q & ~hit(wb_adr_i, EIL_OFF_SCR) & ~hit(wb_adr_i, EIL_OFF_BRK)
            & ~hit(wb_adr_i, EIL_OFF_EVT) & ~hit(wb_adr_i, EIL_OFF_EMSK);
    endsequence

    sequence latch_rise_s;
        ~latch_q ##1 latch_q;
    endsequence

    ack_single_a: assert property (wb_ack_o |=> ~wb_ack_o)
        else $error("ack held longer than one cycle");

    ack_cause_a: assert property (wb_ack_o |-> $past(req))
        else $error("ack without a request");

    idle_quiet_a: assert property (~req |=> ~wb_ack_o)
        else $error("ack while bus idle");

    rdat_hold_a: assert property (~(req & ~ack_q & ~wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    wr_no_rdat_a: assert property (wb_ack_o & wb_we_i |-> $stable(wb_dat_o))
        else $error("write disturbed read data");

    unmapped_zero_a: assert property (unmapped_rd_s |=> wb_dat_o == '0)
        else $error("unmapped read not zero");

    scr_read_a: assert property (rd_at_s(EIL_OFF_SCR) |=>
                                 wb_dat_o[EIL_SCR_MODE] == $past(mode_q) && wb_dat_o[EIL_SCR_MASK] == $past(mask_q))
        else $error("control bits read wrong");

    scr_upper_a: assert property (rd_at_s(EIL_OFF_SCR) |=> wb_dat_o[EIL_DW-1:4] == '0)
        else $error("unused control bits read nonzero");

    brk_read_a: assert property (rd_at_s(EIL_OFF_BRK) |=> wb_dat_o[EIL_BRK_BCE] == $past(bce_q))
        else $error("break enable read wrong");

    evt_read_a: assert property (rd_at_s(EIL_OFF_EVT) |=> wb_dat_o[EIL_EVT_NUM-1:0] == $past(evt_q))
        else $error("event status read wrong");

    emsk_read_a: assert property (rd_at_s(EIL_OFF_EMSK) |=> wb_dat_o[EIL_EVT_NUM-1:0] == $past(emsk_q))
        else $error("event mask read wrong");

    // register writes land on the ack edge and nowhere else
    scr_write_a: assert property (wr_at_s(EIL_OFF_SCR) |=>
                                  mode_q == $past(wb_dat_i[EIL_SCR_MODE]) && mask_q == $past(wb_dat_i[EIL_SCR_MASK]))
        else $error("control write did not land");

    brk_write_a: assert property (wr_at_s(EIL_OFF_BRK) |=> bce_q == $past(wb_dat_i[EIL_BRK_BCE]))
        else $error("break enable write did not land");

    emsk_write_a: assert property (wr_at_s(EIL_OFF_EMSK) |=> emsk_q == $past(wb_dat_i[EIL_EVT_NUM-1:0]))
        else $error("event mask write did not land");

    scr_hold_a: assert property (~(wr_lane0 & hit(wb_adr_i, EIL_OFF_SCR)) |=> $stable(mode_q) && $stable(mask_q))
        else $error("control bits changed without a write");

    // sticky events
    evt_edge_a: assert property (pin.fall |=> evt_q[EIL_EVT_EDGE])
        else $error("edge event not recorded");

    evt_vec_a: assert property (vec_fetch_i |=> evt_q[EIL_EVT_VEC])
        else $error("fetch event not recorded");

    evt_clear_a: assert property (wr_at_s(EIL_OFF_EVT) ##0 (wb_dat_i[EIL_EVT_EDGE] & ~pin.fall)
                                  |=> ~evt_q[EIL_EVT_EDGE])
        else $error("edge event not cleared by write one");

    evt_hold_a: assert property (evt_q[EIL_EVT_EDGE] & ~(wr_lane0 & hit(wb_adr_i, EIL_OFF_EVT) & wb_dat_i[EIL_EVT_EDGE])
                                 |=> evt_q[EIL_EVT_EDGE])
        else $error("edge event dropped without a clear");

    irq_clear_a: assert property (~|(evt_q & emsk_q) |-> ~irq_o)
        else $error("interrupt output high with no unmasked event");

    // latch and request path
    latch_cause_a: assert property (latch_rise_s |-> $past(pin.fall))
        else $error("latch set without a falling edge");

    edge_pend_a: assert property (~mode_q |-> pending == latch_q)
        else $error("edge mode pending differs from latch");

    level_drop_a: assert property (mode_q & ~latch_q & ~pin.pin_low |-> ~pending)
        else $error("level request pending with pin high");

    brk_block_a: assert property (break_state_i & ~bce_q |-> ~sw_ack_eff)
        else $error("software ack effective during break");

    ack_path_a: assert property (sw_ack_eff |-> sw_ack)
        else $error("ack effective without a write");

    req_source_a: assert property (cpu_req_o |-> pending & ~mask_q)
        else $error("request without an unmasked pending source");

    fall_single_a: assert property (pin.fall |=> ~pin.fall)
        else $error("edge flagged on two cycles");

    reset_quiet_a: assert property ($fell(rst_i) |->
                                    ~wb_ack_o && ~irq_o && wb_dat_o == '0 && ~pin.fall)
        else $error("outputs not quiet after reset");
endmodule : eil_ext_int
`default_nettype wire

// *** eil_cpu_model.sv ***
// far side model: interrupt source pin and cpu vector fetch
`timescale 1ns/100ps
`default_nettype none
module eil_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cpu_req_i,
    input wire logic fetch_en_i,
    input wire logic pin_low_i,
    output logic irq_pin_n_o,
    output logic vec_fetch_o
);
    logic [1:0] wait_q;
    // pin has a pull-up, so idle is high
    always_ff @(posedge clk_i) begin
        irq_pin_n_o <= ~pin_low_i;
    end
    // fetch pulse three cycles after a request shows, repeated every four cycles while it stays
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_q <= 2'h0;
            vec_fetch_o <= 1'b0;
        end else begin
            vec_fetch_o <= (wait_q == 2'h2);
            wait_q <= (fetch_en_i && cpu_req_i && !vec_fetch_o) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule : eil_cpu_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the external interrupt latch
`timescale 1ns/100ps
`default_nettype none
module testbench
    import eil_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pin_low = 1'b0;
    logic fetch_en = 1'b0;
    logic brk = 1'b0;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] dout;
    logic [31:0] rd;
    logic pin_n, vec, req, irq, ack;
    int num_errors = 0;
    int num_checks = 0;
    always #2 clk_i = ~clk_i;
    eil_cpu_model mdl (.clk_i(clk_i), .rst_i(rst_i), .cpu_req_i(req), .fetch_en_i(fetch_en),
        .pin_low_i(pin_low), .irq_pin_n_o(pin_n), .vec_fetch_o(vec));
    eil_ext_int uut (.clk_i(clk_i), .rst_i(rst_i), .irq_pin_n_i(pin_n), .vec_fetch_i(vec),
        .break_state_i(brk), .cpu_req_o(req), .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack));
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dout;
        cyc <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            finish_test();
        end
    endtask : wb
    task automatic sreg(input logic [31:0] e);
        wb(1'b0, EIL_OFF_SCR, 32'h0);
        chk("scr", e, rd);
    endtask : sreg
    task automatic pin(input logic l);
        @(posedge clk_i);
        pin_low <= l;
        repeat (10) @(posedge clk_i);
    endtask : pin
    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset
    task automatic t_edge;
        pin(1'b1);
        chk("req", 32'h1, req);
        pin(1'b0);
        sreg(32'h8);
        wb(1'b1, EIL_OFF_SCR, 32'h4);
        sreg(32'h0);
    endtask : t_edge
    task automatic t_fetch;
        wb(1'b1, EIL_OFF_EVT, 32'h3);
        fetch_en <= 1'b1;
        pin(1'b1);
        chk("req", 32'h0, req);
        sreg(32'h0);
        wb(1'b0, EIL_OFF_EVT, 32'h0);
        chk("evt", 32'h3, rd);
        fetch_en <= 1'b0;
        pin(1'b0);
    endtask : t_fetch
    task automatic t_mask;
        wb(1'b1, EIL_OFF_SCR, 32'h2);
        pin(1'b1);
        chk("req", 32'h0, req);
        sreg(32'hA);
        wb(1'b1, EIL_OFF_SCR, 32'h0);
        @(posedge clk_i);
        chk("req", 32'h1, req);
        wb(1'b1, EIL_OFF_SCR, 32'h4);
        pin(1'b0);
    endtask : t_mask
    task automatic t_level;
        wb(1'b1, EIL_OFF_SCR, 32'h1);
        pin(1'b1);
        sreg(32'h9);
        wb(1'b1, EIL_OFF_SCR, 32'h5);
        sreg(32'h9);
        pin(1'b0);
        sreg(32'h1);
        pin(1'b1);
        pin(1'b0);
        sreg(32'h9);
        wb(1'b1, EIL_OFF_SCR, 32'h5);
        sreg(32'h1);
        pin(1'b1);
        do_reset();
        sreg(32'h0);
        chk("req", 32'h0, req);
        pin(1'b0);
    endtask : t_level
    task automatic t_break;
        brk <= 1'b1;
        pin(1'b1);
        pin(1'b0);
        wb(1'b1, EIL_OFF_SCR, 32'h4);
        sreg(32'h8);
        wb(1'b1, EIL_OFF_BRK, 32'h1);
        wb(1'b1, EIL_OFF_SCR, 32'h4);
        brk <= 1'b0;
        sreg(32'h0);
    endtask : t_break
    task automatic t_irq;
        wb(1'b1, EIL_OFF_EVT, 32'h3);
        wb(1'b1, EIL_OFF_EMSK, 32'h1);
        chk("irq", 32'h0, irq);
        pin(1'b1);
        chk("irq", 32'h1, irq);
        wb(1'b1, EIL_OFF_EVT, 32'h1);
        @(posedge clk_i);
        chk("irq", 32'h0, irq);
        wb(1'b1, 8'h40, 32'hF);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        sreg(32'h8);
    endtask : t_irq
    initial begin
        do_reset();
        sreg(32'h0);
        t_edge();
        t_fetch();
        t_mask();
        t_level();
        t_break();
        t_irq();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
